//--- rtl/rtp_timer.sv
`timescale 1ns/1ps
`include "rtp_defines.svh"
// What this block does
// - Periodic output toggles every half period.
// - Sixteen-cycle setting follows prescaler bit three.
// - First periodic interrupt depends on prescaler phase.
// - Correction enable applies signed trim to prescaler.
// - Trim magnitude cycles spread over million cycles.
// - Counter and periodic intervals both see correction.
// - Disabling correction finishes the running interval.
// - Wrap and match events pulse with flags.
// - Eight level taps, divide 64 to 8192.
// - Wrap when counter hits period, back to zero.
// - Match when counter equals compare value.
// - Periodic flag each selected interval.
// - Request while flag and enable both set.
// - Separate flags and enables, two requests.
// - Counter stops in standby without run bit.
// - Periodic timer runs in every sleep mode.
// - Busy flags for compare, period, count, control.
// - Separate busy flag for periodic control writes.
// - Counter halts with CPU unless bypass set.
// - Periodic output low in halt without bypass; resume edge flags.
// - Writing one clears a flag, zero keeps.
// - Periodic interval powers of two, 4 to 32768.
module rtp_timer #(
	parameter int CORR_INTERVAL = `RTP_CORR_INTERVAL
) (
	// Clock and reset.
	input wire logic clk_sys,
	input wire logic arst_n,
	// Register port.
	input wire logic [4:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [7:0] reg_rdata,
	// System state.
	input wire logic cpu_halted,
	input wire logic sleep_standby,
	// Interrupt requests.
	output logic rtc_irq,
	output logic pit_irq,
	// Events and periodic output.
	output logic wrap_event,
	output logic match_event,
	output logic [7:0] tap_level_event,
	output logic periodic_out
);
	import rtp_pkg::*;

	// Registered and next state.
	rtp_state_t s_reg;
	rtp_state_t s_next;

	// Combinational helpers.
	logic pre_run;
	logic boundary;
	logic fire;
	logic [19:0] corr_sum;
	logic [1:0] step;
	logic [15:0] presc_sum;
	logic tick;
	logic rtc_run;
	logic pit_hold;
	logic pit_now;
	logic [1:0] set_f;
	logic [1:0] clr_f;
	logic pit_set;
	logic pit_clr;

	// True when the counter crosses a multiple of the selected division.
	function automatic logic rtp_carry(input logic [15:0] old_v, input logic [15:0] new_v,
		input logic [3:0] sel);
		return (old_v >> sel) != (new_v >> sel);
	endfunction

	// Level of the periodic square wave for a prescaler value and control byte.
	function automatic logic rtp_pit_level(input logic [14:0] pv, input logic [7:0] pc);
		logic [3:0] v;
		v = pc[`RTP_F_PERIOD];
		if (!pc[`RTP_B_PERIODIC_TIMER_ENABLE] || v == 4'h0 || v > `RTP_PIT_MAXSEL) begin
			return 1'b0;
		end
		return pv[v];
	endfunction

	// Next-state logic for the whole block.
	always_comb begin
		s_next = s_reg;
		s_next.rdata = 8'h00;
		s_next.wrap_ev = 1'b0;
		s_next.match_ev = 1'b0;
		set_f = 2'h0;
		clr_f = 2'h0;
		pit_set = 1'b0;
		pit_clr = 1'b0;

		// The shared prescaler runs while either function is on.
		pre_run = s_reg.ctrla[`RTP_B_RTCEN] | s_reg.periodic_control_register[`RTP_B_PERIODIC_TIMER_ENABLE];
		boundary = s_reg.corr_int == 20'(CORR_INTERVAL - 1);
		corr_sum = s_reg.corr_acc + {13'h0000, s_reg.crystal_trim_register[`RTP_F_ERROR]};
		// Accumulator fires exactly error-count times per interval.
		fire = s_reg.corr_run && (corr_sum >= 20'(CORR_INTERVAL));
		// Negative trim skips a count, positive trim holds one cycle.
		if (!fire) begin
			step = 2'h1;
		end else if (s_reg.crystal_trim_register[`RTP_B_SIGN]) begin
			step = 2'h2;
		end else begin
			step = 2'h0;
		end
		presc_sum = {1'b0, s_reg.presc} + {14'h0000, step};
		// Counter ticks come from the corrected prescaler.
		tick = pre_run && rtp_carry({1'b0, s_reg.presc}, presc_sum,
			s_reg.ctrla[`RTP_F_PRESC]);

		// Prescaler and correction interval; cleared when both functions are off.
		if (pre_run) begin
			s_next.presc = presc_sum[14:0];
			s_next.corr_int = boundary ? 20'h00000 : s_reg.corr_int + 20'h00001;
			// An idle accumulator stays empty, so enabling mid-interval cannot burst fires.
			if (boundary || !s_reg.corr_run) begin
				s_next.corr_acc = 20'h00000;
			end else if (fire) begin
				s_next.corr_acc = corr_sum - 20'(CORR_INTERVAL);
			end else begin
				s_next.corr_acc = corr_sum;
			end
			// A cleared enable only stops correction at the interval end.
			s_next.corr_run = s_reg.ctrla[`RTP_B_CORRECTION_ENABLE] | (s_reg.corr_run & ~boundary);
		end else begin
			s_next.presc = 15'h0000;
			s_next.corr_int = 20'h00000;
			s_next.corr_acc = 20'h00000;
			s_next.corr_run = 1'b0;
		end

		// Counter: idle sleep keeps it running, standby needs the run bit.
		rtc_run = s_reg.ctrla[`RTP_B_RTCEN]
			&& !(sleep_standby && !s_reg.ctrla[`RTP_B_RUN_IN_STANDBY])
			&& !(cpu_halted && !s_reg.halt_bypass);
		if (rtc_run && tick) begin
			// Match is flagged on the count after equality.
			if (s_reg.cnt == s_reg.cmp) begin
				set_f[`RTP_B_MATCH] = 1'b1;
				s_next.match_ev = 1'b1;
			end
			// Wrap to zero on the count after reaching the period.
			if (s_reg.cnt == s_reg.per) begin
				s_next.cnt = 16'h0000;
				set_f[`RTP_B_WRAP] = 1'b1;
				s_next.wrap_ev = 1'b1;
			end else begin
				s_next.cnt = s_reg.cnt + 16'h0001;
			end
		end

		// Periodic wave ignores sleep; a halt without bypass forces it low.
		pit_hold = cpu_halted && !s_reg.pitdbg;
		pit_now = rtp_pit_level(s_reg.presc, s_reg.periodic_control_register) && !pit_hold;
		s_next.pit_out = pit_now;
		// Each rising edge marks one elapsed interval.
		if (pit_now && !s_reg.pit_out) begin
			pit_set = 1'b1;
		end

		// Pending crossings count down and land on their last cycle.
		for (int i = 0; i < 5; i++) begin
			if (s_reg.sync[i] != 2'h0) begin
				s_next.sync[i] = s_reg.sync[i] - 2'h1;
			end
		end
		if (s_reg.sync[`RTP_S_CTRLA] == 2'h1) begin
			s_next.ctrla = s_reg.stage[`RTP_S_CTRLA][7:0];
		end
		if (s_reg.sync[`RTP_S_CNT] == 2'h1) begin
			s_next.cnt = s_reg.stage[`RTP_S_CNT];
		end
		if (s_reg.sync[`RTP_S_PER] == 2'h1) begin
			s_next.per = s_reg.stage[`RTP_S_PER];
		end
		if (s_reg.sync[`RTP_S_CMP] == 2'h1) begin
			s_next.cmp = s_reg.stage[`RTP_S_CMP];
		end
		if (s_reg.sync[`RTP_S_PIT] == 2'h1) begin
			s_next.periodic_control_register = s_reg.stage[`RTP_S_PIT][7:0];
		end

		// Register writes; crossing registers go through a staging slot.
		if (reg_wr) begin
			case (reg_addr)
				`RTP_A_CTRLA: begin
					s_next.stage[`RTP_S_CTRLA] = {8'h00, reg_wdata};
					s_next.sync[`RTP_S_CTRLA] = `RTP_SYNC_CYC;
				end
				`RTP_A_IRQ_ENABLE_REGISTER: s_next.irq_enable_register = reg_wdata[1:0];
				`RTP_A_IRQ_FLAG_REGISTER: clr_f = reg_wdata[1:0];
				`RTP_A_TEMP: s_next.temp = reg_wdata;
				`RTP_A_HALT_CONTROL_REGISTER: s_next.halt_bypass = reg_wdata[0];
				`RTP_A_CRYSTAL_TRIM_REGISTER: s_next.crystal_trim_register = reg_wdata;
				`RTP_A_CLKSEL: s_next.clksel = reg_wdata[1:0];
				`RTP_A_CNT_L, `RTP_A_PER_L, `RTP_A_CMP_L: s_next.temp = reg_wdata;
				`RTP_A_CNT_H: begin
					s_next.stage[`RTP_S_CNT] = {reg_wdata, s_reg.temp};
					s_next.sync[`RTP_S_CNT] = `RTP_SYNC_CYC;
				end
				`RTP_A_PER_H: begin
					s_next.stage[`RTP_S_PER] = {reg_wdata, s_reg.temp};
					s_next.sync[`RTP_S_PER] = `RTP_SYNC_CYC;
				end
				`RTP_A_CMP_H: begin
					s_next.stage[`RTP_S_CMP] = {reg_wdata, s_reg.temp};
					s_next.sync[`RTP_S_CMP] = `RTP_SYNC_CYC;
				end
				`RTP_A_PERIODIC_CONTROL_REGISTER: begin
					s_next.stage[`RTP_S_PIT] = {8'h00, reg_wdata};
					s_next.sync[`RTP_S_PIT] = `RTP_SYNC_CYC;
				end
				`RTP_A_PERIODIC_IRQ_ENABLE_REGISTER: s_next.pitinten = reg_wdata[0];
				`RTP_A_PERIODIC_IRQ_FLAG_REGISTER: pit_clr = reg_wdata[0];
				`RTP_A_PERIODIC_HALT_REGISTER: s_next.pitdbg = reg_wdata[0];
				default: begin
				end
			endcase
		end

		// Register reads; low byte of a pair parks the high byte in temp.
		if (reg_rd) begin
			case (reg_addr)
				`RTP_A_CTRLA: s_next.rdata = s_reg.ctrla;
				`RTP_A_STATUS: begin
					s_next.rdata = {4'h0, s_reg.sync[`RTP_S_CMP] != 2'h0,
						s_reg.sync[`RTP_S_PER] != 2'h0, s_reg.sync[`RTP_S_CNT] != 2'h0,
						s_reg.sync[`RTP_S_CTRLA] != 2'h0};
				end
				`RTP_A_IRQ_ENABLE_REGISTER: s_next.rdata = {6'h00, s_reg.irq_enable_register};
				`RTP_A_IRQ_FLAG_REGISTER: s_next.rdata = {6'h00, s_reg.irq_flag_register};
				`RTP_A_TEMP: s_next.rdata = s_reg.temp;
				`RTP_A_HALT_CONTROL_REGISTER: s_next.rdata = {7'h00, s_reg.halt_bypass};
				`RTP_A_CRYSTAL_TRIM_REGISTER: s_next.rdata = s_reg.crystal_trim_register;
				`RTP_A_CLKSEL: s_next.rdata = {6'h00, s_reg.clksel};
				`RTP_A_CNT_L: begin
					s_next.rdata = s_reg.cnt[7:0];
					s_next.temp = s_reg.cnt[15:8];
				end
				`RTP_A_PER_L: begin
					s_next.rdata = s_reg.per[7:0];
					s_next.temp = s_reg.per[15:8];
				end
				`RTP_A_CMP_L: begin
					s_next.rdata = s_reg.cmp[7:0];
					s_next.temp = s_reg.cmp[15:8];
				end
				`RTP_A_CNT_H, `RTP_A_PER_H, `RTP_A_CMP_H: s_next.rdata = s_reg.temp;
				`RTP_A_PERIODIC_CONTROL_REGISTER: s_next.rdata = s_reg.periodic_control_register;
				`RTP_A_PERIODIC_STATUS_REGISTER: s_next.rdata = {7'h00, s_reg.sync[`RTP_S_PIT] != 2'h0};
				`RTP_A_PERIODIC_IRQ_ENABLE_REGISTER: s_next.rdata = {7'h00, s_reg.pitinten};
				`RTP_A_PERIODIC_IRQ_FLAG_REGISTER: s_next.rdata = {7'h00, s_reg.pitflag};
				`RTP_A_PERIODIC_HALT_REGISTER: s_next.rdata = {7'h00, s_reg.pitdbg};
				default: s_next.rdata = 8'h00;
			endcase
		end

		// Hardware set wins over a same-cycle software clear.
		s_next.irq_flag_register = (s_reg.irq_flag_register & ~clr_f) | set_f;
		s_next.pitflag = (s_reg.pitflag & ~pit_clr) | pit_set;
	end

	// State register.
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			s_reg <= '0;
			s_reg.ctrla <= `RTP_CTRLA_RST;
			s_reg.per <= `RTP_PER_RST;
		end else begin
			s_reg <= s_next;
		end
	end

	// Outputs; the two requests are kept apart.
	assign reg_rdata = s_reg.rdata;
	assign rtc_irq = |(s_reg.irq_flag_register & s_reg.irq_enable_register);
	assign pit_irq = s_reg.pitflag & s_reg.pitinten;
	assign wrap_event = s_reg.wrap_ev;
	assign match_event = s_reg.match_ev;
	assign periodic_out = s_reg.pit_out;

	// Level taps follow prescaler bits five through twelve.
	for (genvar g = 0; g < 8; g++) begin : g_tap
		assign tap_level_event[g] = s_reg.presc[`RTP_TAP_LSB + g];
	end

	// Checks on the block's own behaviour.
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!arst_n);

	logic pit16_cfg;
	assign pit16_cfg = s_reg.periodic_control_register[`RTP_F_PERIOD] == `RTP_SIXTEEN_CYCLE_SETTING
		&& s_reg.periodic_control_register[`RTP_B_PERIODIC_TIMER_ENABLE] && !pit_hold;

	pit_bit3_a: assert property (pit16_cfg |=> periodic_out == $past(s_reg.presc[3]))
		else $error("periodic output does not follow prescaler bit 3");
	pit_flag_a: assert property ($rose(periodic_out) |-> s_reg.pitflag)
		else $error("periodic rising edge did not set its flag");
	pit_low_a: assert property (pit_hold |=> !periodic_out)
		else $error("periodic output not low during halt");
	wrap_event_a: assert property (wrap_event |-> s_reg.irq_flag_register[`RTP_B_WRAP]
		&& (s_reg.cnt == 16'h0000 || $past(s_reg.sync[`RTP_S_CNT] == 2'h1)))
		else $error("wrap event without flag or zero count");
	match_event_a: assert property (match_event |-> s_reg.irq_flag_register[`RTP_B_MATCH]
		&& $past(s_reg.cnt == s_reg.cmp))
		else $error("match event without equality");
	cmp_busy_a: assert property (reg_wr && reg_addr == `RTP_A_CMP_H
		|=> (s_reg.sync[`RTP_S_CMP] != 2'h0) [*2])
		else $error("compare busy flag not held for two cycles");
	busy_apply_a: assert property ($fell(s_reg.sync[`RTP_S_CMP] != 2'h0)
		|-> s_reg.cmp == $past(s_reg.stage[`RTP_S_CMP]))
		else $error("busy cleared before value applied");
	pit_busy_a: assert property (reg_wr && reg_addr == `RTP_A_PERIODIC_CONTROL_REGISTER
		|=> s_reg.sync[`RTP_S_PIT] != 2'h0)
		else $error("periodic control busy flag not set");
	standby_stop_a: assert property (sleep_standby && !s_reg.ctrla[`RTP_B_RUN_IN_STANDBY]
		&& s_reg.sync[`RTP_S_CNT] != 2'h1 |=> $stable(s_reg.cnt))
		else $error("counter moved in standby");
	halt_stop_a: assert property (cpu_halted && !s_reg.halt_bypass
		&& s_reg.sync[`RTP_S_CNT] != 2'h1 |=> $stable(s_reg.cnt))
		else $error("counter moved while halted");
	corr_finish_a: assert property (s_reg.corr_run && !boundary && pre_run
		|=> s_reg.corr_run)
		else $error("correction stopped inside an interval");
	irq_hold_a: assert property (pit_irq && !(reg_wr && reg_addr == `RTP_A_PERIODIC_IRQ_FLAG_REGISTER)
		&& !(reg_wr && reg_addr == `RTP_A_PERIODIC_IRQ_ENABLE_REGISTER) |=> pit_irq)
		else $error("periodic request dropped without clear");

	wrap_seen_c: cover property (wrap_event);
	match_seen_c: cover property (match_event);
	pit_irq_c: cover property ($rose(pit_irq));
	corr_fire_c: cover property (fire);

endmodule // rtp_timer

//--- rtl/rtp_defines.svh
`ifndef RTP_DEFINES_SVH
`define RTP_DEFINES_SVH

// Register byte offsets.
`define RTP_A_CTRLA 5'h00
`define RTP_A_STATUS 5'h01
`define RTP_A_IRQ_ENABLE_REGISTER 5'h02
`define RTP_A_IRQ_FLAG_REGISTER 5'h03
`define RTP_A_TEMP 5'h04
`define RTP_A_HALT_CONTROL_REGISTER 5'h05
`define RTP_A_CRYSTAL_TRIM_REGISTER 5'h06
`define RTP_A_CLKSEL 5'h07
`define RTP_A_CNT_L 5'h08
`define RTP_A_CNT_H 5'h09
`define RTP_A_PER_L 5'h0A
`define RTP_A_PER_H 5'h0B
`define RTP_A_CMP_L 5'h0C
`define RTP_A_CMP_H 5'h0D
`define RTP_A_PERIODIC_CONTROL_REGISTER 5'h10
`define RTP_A_PERIODIC_STATUS_REGISTER 5'h11
`define RTP_A_PERIODIC_IRQ_ENABLE_REGISTER 5'h12
`define RTP_A_PERIODIC_IRQ_FLAG_REGISTER 5'h13
`define RTP_A_PERIODIC_HALT_REGISTER 5'h15

// Field positions.
`define RTP_B_RTCEN 0
`define RTP_B_CORRECTION_ENABLE 2
`define RTP_B_RUN_IN_STANDBY 7
`define RTP_F_PRESC 6:3
`define RTP_B_PERIODIC_TIMER_ENABLE 0
`define RTP_F_PERIOD 6:3
`define RTP_B_SIGN 7
`define RTP_F_ERROR 6:0
`define RTP_B_WRAP 0
`define RTP_B_MATCH 1
`define RTP_TAP_LSB 5

// Indices of the write paths that cross into the timer logic.
`define RTP_S_CTRLA 0
`define RTP_S_CNT 1
`define RTP_S_PER 2
`define RTP_S_CMP 3
`define RTP_S_PIT 4

// Reset values and timing counts.
`define RTP_CTRLA_RST 8'h00
`define RTP_PER_RST 16'hFFFF
`define RTP_SYNC_CYC 2'h2
`define RTP_CORR_INTERVAL 1000000
`define RTP_SIXTEEN_CYCLE_SETTING 4'h3
`define RTP_PIT_MAXSEL 4'hE

`endif

//--- rtl/rtp_pkg.sv
package rtp_pkg;

	// Complete state of the timer block.
	typedef struct packed {
		logic [7:0] ctrla;
		logic [1:0] irq_enable_register;
		logic [1:0] irq_flag_register;
		logic [7:0] temp;
		logic halt_bypass;
		logic [7:0] crystal_trim_register;
		logic [1:0] clksel;
		logic [15:0] cnt;
		logic [15:0] per;
		logic [15:0] cmp;
		logic [7:0] periodic_control_register;
		logic pitinten;
		logic pitflag;
		logic pitdbg;
		logic [14:0] presc;
		logic pit_out;
		logic [4:0][15:0] stage;
		logic [4:0][1:0] sync;
		logic [19:0] corr_int;
		logic [19:0] corr_acc;
		logic corr_run;
		logic [7:0] rdata;
		logic wrap_ev;
		logic match_ev;
	} rtp_state_t;

endpackage

//--- tb/tb_top.sv
`timescale 1ns/1ps
`include "rtp_defines.svh"
// Compares a design value with its expectation and counts the outcome.
`define CHK(got, exp) begin n_checks++; if ((got) !== (exp)) begin n_fail++; \
	$display("wrong value at %0t: got %h expected %h", $time, got, exp); end end
module tb_top;
	// Clock, reset and register port.
	logic clk_sys = 1'b0;
	logic arst_n = 1'b0;
	logic [4:0] reg_addr = 5'h00;
	logic [7:0] reg_wdata = 8'h00;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic [7:0] reg_rdata;
	// System state inputs.
	logic cpu_halted = 1'b0;
	logic sleep_standby = 1'b0;
	// Requests, events and periodic output.
	logic rtc_irq;
	logic pit_irq;
	logic wrap_event;
	logic match_event;
	logic [7:0] tap_level_event;
	logic periodic_out;
	// Counters of comparisons and mismatches.
	int n_checks = 0;
	int n_fail = 0;
	// Scratch values shared by the sequence.
	logic [7:0] d;
	int hi, per, nw, nm;

	// The interval is shortened so that correction would settle quickly.
	rtp_timer #(.CORR_INTERVAL(200)) u_rtp_timer (
		.clk_sys(clk_sys), .arst_n(arst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .cpu_halted(cpu_halted),
		.sleep_standby(sleep_standby), .rtc_irq(rtc_irq), .pit_irq(pit_irq),
		.wrap_event(wrap_event), .match_event(match_event),
		.tap_level_event(tap_level_event), .periodic_out(periodic_out)
	);

	// The clock runs at 25 MHz.
	always #20 clk_sys = ~clk_sys;

	// Prints the verdict and ends the run.
	task automatic summarize();
		if (n_fail == 0 && n_checks > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask

	// Moves one clock edge on and lets its updates settle.
	task automatic step();
		@(posedge clk_sys);
		#1;
	endtask

	// One write cycle with the strobe high for a single clock.
	task automatic wr(input logic [4:0] a, input logic [7:0] v);
		@(posedge clk_sys);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= v;
		@(posedge clk_sys);
		reg_wr <= 1'b0;
	endtask

	// One read cycle; the data are taken in the cycle after the strobe.
	task automatic rd(input logic [4:0] a, output logic [7:0] v);
		@(posedge clk_sys);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge clk_sys);
		reg_rd <= 1'b0;
		#1;
		v = reg_rdata;
	endtask

	// Polls a status register until every busy bit has dropped, with a bound.
	task automatic idle(input logic [4:0] a);
		logic [7:0] s;
		int i;
		s = 8'hFF;
		for (i = 0; i < 20 && s !== 8'h00; i++) begin
			rd(a, s);
		end
		`CHK(s, 8'h00)
	endtask

	// Picks the periodic output or one of the level taps.
	function automatic logic sig(input int w);
		return (w == 0) ? periodic_out : tap_level_event[w - 1];
	endfunction

	// Measures the high time and the full cycle between two rising edges.
	task automatic meas(input int w, output int h, output int p);
		logic q;
		int i;
		h = 0;
		p = 0;
		q = sig(w);
		step();
		for (i = 0; i < 20000 && !(sig(w) === 1'b1 && q === 1'b0); i++) begin
			q = sig(w);
			step();
		end
		for (i = 0; i < 20000; i++) begin
			if (sig(w) === 1'b1) h++;
			p++;
			q = sig(w);
			step();
			if (sig(w) === 1'b1 && q === 1'b0) break;
		end
	endtask

	// Counts the cycles in which each counter event is high.
	task automatic evc(output int w, output int m);
		w = 0;
		m = 0;
		repeat (40) begin
			step();
			if (wrap_event === 1'b1) w++;
			if (match_event === 1'b1) m++;
		end
	endtask

	// Changes the system state pins just after a rising edge.
	task automatic pins(input logic h, input logic s);
		@(posedge clk_sys);
		cpu_halted <= h;
		sleep_standby <= s;
	endtask

	// Main sequence of tests.
	initial begin
		logic [4:0] adr [3];
		logic [7:0] val [3];
		logic [7:0] bsy [3];
		int i;
		adr = '{`RTP_A_CMP_L, `RTP_A_PER_L, `RTP_A_CNT_L};
		val = '{8'h01, 8'h03, 8'h00};
		bsy = '{8'h08, 8'h04, 8'h02};
		repeat (12) @(posedge clk_sys);
		arst_n <= 1'b1;
		// Each 16-bit write shows its own busy bit while it crosses.
		for (i = 0; i < 3; i++) begin
			wr(adr[i], val[i]);
			wr(adr[i] + 5'h01, 8'h00);
			rd(`RTP_A_STATUS, d);
			`CHK(d, bsy[i])
			idle(`RTP_A_STATUS);
		end
		// Counter enabled with no prescaling.
		wr(`RTP_A_CTRLA, 8'h01);
		rd(`RTP_A_STATUS, d);
		`CHK(d, 8'h01)
		idle(`RTP_A_STATUS);
		// With a top of 3 the counter wraps and matches every fourth cycle.
		evc(nw, nm);
		`CHK(nw, 10)
		`CHK(nm, 10)
		rd(`RTP_A_IRQ_FLAG_REGISTER, d);
		`CHK(d, 8'h03)
		`CHK(rtc_irq, 1'b0)
		wr(`RTP_A_IRQ_ENABLE_REGISTER, 8'h01);
		step();
		`CHK(rtc_irq, 1'b1)
		// Standby stops the counter unless the run bit is set.
		pins(1'b0, 1'b1);
		evc(nw, nm);
		`CHK(nw, 0)
		wr(`RTP_A_CTRLA, 8'h81);
		idle(`RTP_A_STATUS);
		evc(nw, nm);
		`CHK(nw, 10)
		// A halted CPU stops the counter unless the bypass bit is set.
		pins(1'b1, 1'b0);
		evc(nw, nm);
		`CHK(nw, 0)
		wr(`RTP_A_HALT_CONTROL_REGISTER, 8'h01);
		evc(nw, nm);
		`CHK(nw, 10)
		pins(1'b0, 1'b0);
		// Stop the counter; a zero write keeps both flags, ones clear them.
		wr(`RTP_A_CTRLA, 8'h00);
		idle(`RTP_A_STATUS);
		wr(`RTP_A_IRQ_FLAG_REGISTER, 8'h00);
		rd(`RTP_A_IRQ_FLAG_REGISTER, d);
		`CHK(d, 8'h03)
		wr(`RTP_A_IRQ_FLAG_REGISTER, 8'h03);
		rd(`RTP_A_IRQ_FLAG_REGISTER, d);
		`CHK(d, 8'h00)
		`CHK(rtc_irq, 1'b0)
		// Periodic output across several interval settings.
		wr(`RTP_A_PERIODIC_IRQ_ENABLE_REGISTER, 8'h01);
		for (i = 1; i <= 4; i++) begin
			wr(`RTP_A_PERIODIC_CONTROL_REGISTER, 8'((i << 3) | 1));
			rd(`RTP_A_PERIODIC_STATUS_REGISTER, d);
			`CHK(d, 8'h01)
			idle(`RTP_A_PERIODIC_STATUS_REGISTER);
			meas(0, hi, per);
			`CHK(per, 2 << i)
			`CHK(hi, 1 << i)
			`CHK(pit_irq, 1'b1)
			`CHK(rtc_irq, 1'b0)
		end
		// Level taps follow the prescaler divided by 64 and by 8192.
		meas(1, hi, per);
		`CHK(per, 64)
		meas(8, hi, per);
		`CHK(per, 8192)
		// The periodic timer keeps running in standby.
		pins(1'b0, 1'b1);
		meas(0, hi, per);
		`CHK(per, 32)
		// Halt forces the output low; the resume edge sets the flag again.
		pins(1'b1, 1'b0);
		wr(`RTP_A_PERIODIC_IRQ_FLAG_REGISTER, 8'h01);
		hi = 0;
		repeat (40) begin
			step();
			if (periodic_out !== 1'b0) hi++;
		end
		`CHK(hi, 0)
		`CHK(pit_irq, 1'b0)
		pins(1'b0, 1'b0);
		meas(0, hi, per);
		`CHK(pit_irq, 1'b1)
		// With top 0 every counter tick is a wrap, so wraps count the ticks.
		wr(`RTP_A_CNT_L, 8'h00);
		wr(`RTP_A_CNT_H, 8'h00);
		wr(`RTP_A_PER_L, 8'h00);
		wr(`RTP_A_PER_H, 8'h00);
		idle(`RTP_A_STATUS);
		// Positive trim of 5 holds the prescaler 10 times in two intervals.
		wr(`RTP_A_CRYSTAL_TRIM_REGISTER, 8'h05);
		wr(`RTP_A_CTRLA, 8'h05);
		idle(`RTP_A_STATUS);
		repeat (5) evc(nw, nm);
		hi = 0;
		repeat (10) begin
			evc(nw, nm);
			hi += nw;
		end
		`CHK(hi, 390)
		// Negative trim needs the halve setting before the sign is turned.
		wr(`RTP_A_CTRLA, 8'h0D);
		idle(`RTP_A_STATUS);
		wr(`RTP_A_CRYSTAL_TRIM_REGISTER, 8'h85);
		repeat (5) evc(nw, nm);
		hi = 0;
		repeat (10) begin
			evc(nw, nm);
			hi += nw;
		end
		`CHK(hi, 205)
		summarize();
	end

	// Cuts a hang short well beyond the expected run length.
	initial begin
		#(40 * 60000);
		n_fail++;
		summarize();
	end
endmodule // tb_top
